// file: core/nfc_ctrl.sv
// nand flash host controller: erase, status poll, id read, reset.
// assumes a flash with open-drain ready/busy pulled up externally;
// registers reached over a simple one-cycle strobe port.
//
// Function
// - erase: setup 60H then two address cycles
// - erase starts only after confirm D0H
// - 70H then read cycles give status
// - status mode holds; reissue 00H/50H for data
// - 90H, address 00H, then two id bytes
// - hold write-protect low over power edges
// - only status and reset while busy
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module nfc_ctrl
  import nfc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic irq_out,
  input wire logic [7:0] fl_io_in,
  output logic [7:0] fl_io_out,
  output logic fl_io_oe_n_out,
  output logic fl_cle_out,
  output logic fl_ale_out,
  output logic fl_ce_n_out,
  output logic fl_we_n_out,
  output logic fl_read_strobe_low_out,
  output logic fl_wp_n_out,
  input wire logic fl_rdy_in
);
  typedef enum logic [3:0] {
    S_IDLE, S_CMD, S_ADDR0, S_ADDR1, S_CONF, S_WAITB, S_WAITR, S_STAT,
    S_ID0, S_ID1
  } nfc_seq_t;
  nfc_pins_if pins();
  logic [7:0] s_io, rd_q, ret_q;
  logic s_oe_n, s_cle, s_ale, s_we_n, s_rd_stb_n;

  nfc_strobe u_stb (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .bus(pins.eng),
    .io_in(fl_io_in),
    .io_out(s_io),
    .io_oe_n_out(s_oe_n),
    .cle_out(s_cle),
    .ale_out(s_ale),
    .we_n_out(s_we_n),
    .read_strobe_low_out(s_rd_stb_n)
  );
  nfc_seq_t st_r, st_nxt;
  logic [2:0] op_r, op_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic [NFC_BLK_W-1:0] blk_r, blk_nxt;
  logic [7:0] fsr_r, fsr_nxt, mid_r, mid_nxt, did_r, did_nxt;
  logic wpen_r, wpen_nxt, busy_r, busy_nxt;
  logic [2:0] irq_r, irq_nxt, ien_r, ien_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic req_r, req_nxt;
  logic [1:0] kind_r, kind_nxt;
  logic [7:0] wd_r, wd_nxt;
  logic ev_done, ev_fail, ev_rej, cmd_wr;

  // erase address bytes: row byte 1 holds A9..A16, byte 2 A17..A22
  function automatic logic [7:0] addr_byte(input logic [NFC_BLK_W-1:0] b,
                                           input logic hi);
    logic [22:0] a;
    a = 23'(b) << NFC_BLK_LSB; // bits 9..12 left zero, ignored anyway
    addr_byte = hi ? {2'b00, a[22:17]} : a[16:9];
  endfunction

  assign pins.req = req_r;
  assign pins.kind = kind_r;
  assign pins.wdata = wd_r;
  assign cmd_wr = reg_wr_in && (reg_addr_in == NFC_REG_CTRL);

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    cmd_nxt = cmd_r;
    req_nxt = 1'b0;
    kind_nxt = kind_r;
    wd_nxt = wd_r;
    fsr_nxt = fsr_r;
    mid_nxt = mid_r;
    did_nxt = did_r;
    busy_nxt = busy_r;
    ev_done = 1'b0;
    ev_fail = 1'b0;
    ev_rej = 1'b0;
    if (cmd_wr) begin
      // while the flash is busy only status and reset are legal
      if ((busy_r && !(reg_wdata_in[2:0] == NFC_OP_STATUS ||
          reg_wdata_in[2:0] == NFC_OP_RESET)) ||
          !(st_r inside {S_IDLE, S_STAT, S_ID1, S_WAITB}) ||
          // any operation still in flight outside S_WAITB, reset wait included, is refused
          (busy_r && st_r != S_WAITB)) begin
        ev_rej = 1'b1;
      end else begin
        op_nxt = reg_wdata_in[2:0];
        busy_nxt = 1'b1;
        unique case (reg_wdata_in[2:0])
          NFC_OP_ERASE: cmd_nxt = NFC_CMD_ERASE_SETUP;
          NFC_OP_STATUS: cmd_nxt = NFC_CMD_STATUS;
          NFC_OP_ID: cmd_nxt = NFC_CMD_ID;
          NFC_OP_RESET: cmd_nxt = NFC_CMD_RESET;
          NFC_OP_READ_MAIN: cmd_nxt = NFC_CMD_READ_MAIN;
          NFC_OP_READ_SPARE: cmd_nxt = NFC_CMD_READ_SPARE;
          default: begin
            ev_rej = 1'b1;
            busy_nxt = busy_r;
          end
        endcase
        if (!ev_rej) begin
          st_nxt = S_CMD;
          req_nxt = 1'b1;
          kind_nxt = 2'd0;
          wd_nxt = cmd_nxt;
        end
      end
    end else begin
      unique case (st_r)
        S_IDLE, S_STAT, S_ID1: ;
        S_CMD: if (pins.done) begin
          unique case (op_r)
            NFC_OP_ERASE, NFC_OP_ID: begin
              st_nxt = S_ADDR0;
              req_nxt = 1'b1;
              kind_nxt = 2'd1;
              wd_nxt = (op_r == NFC_OP_ID) ? NFC_ID_ADDR :
                addr_byte(blk_r, 1'b0);
            end
            NFC_OP_STATUS: begin
              st_nxt = S_STAT;
              req_nxt = 1'b1;
              kind_nxt = 2'd2;
            end
            NFC_OP_RESET: st_nxt = S_WAITR;
            default: begin
              st_nxt = S_IDLE;
              busy_nxt = 1'b0;
              ev_done = 1'b1;
            end
          endcase
        end
        S_ADDR0: if (pins.done) begin
          req_nxt = 1'b1;
          if (op_r == NFC_OP_ID) begin
            st_nxt = S_ID0;
            kind_nxt = 2'd2;
          end else begin
            st_nxt = S_ADDR1;
            wd_nxt = addr_byte(blk_r, 1'b1);
          end
        end
        S_ADDR1: if (pins.done) begin
          // confirm only ever follows setup plus two addresses
          st_nxt = S_CONF;
          req_nxt = 1'b1;
          kind_nxt = 2'd0;
          wd_nxt = NFC_CMD_ERASE_GO;
        end
        S_CONF: if (pins.done) st_nxt = S_WAITB;
        S_WAITB: if (ret_q[0]) begin
          // flash ready again: fetch the verdict byte
          st_nxt = S_CMD;
          op_nxt = NFC_OP_STATUS;
          req_nxt = 1'b1;
          kind_nxt = 2'd0;
          wd_nxt = NFC_CMD_STATUS;
        end
        S_WAITR: if (ret_q[0]) begin
          st_nxt = S_IDLE;
          busy_nxt = 1'b0;
          ev_done = 1'b1;
        end
        S_ID0: if (pins.done) begin
          mid_nxt = pins.rdata;
          st_nxt = S_ID1;
          req_nxt = 1'b1;
        end
        default: st_nxt = S_IDLE;
      endcase
      if (st_r == S_ID1 && busy_r && pins.done) begin
        did_nxt = pins.rdata;
        busy_nxt = 1'b0;
        ev_done = 1'b1;
      end
      if (st_r == S_STAT && pins.done) begin
        // status mode stays put, so one read cycle per poll
        fsr_nxt = pins.rdata & ~NFC_SR_RSVD_MASK;
        busy_nxt = 1'b0;
        ev_done = 1'b1;
        ev_fail = pins.rdata[NFC_SR_FAIL] &&
          pins.rdata[NFC_SR_READY];
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_r <= S_IDLE;
      op_r <= 3'h0;
      cmd_r <= 8'h00;
      req_r <= 1'b0;
      kind_r <= 2'd0;
      wd_r <= 8'h00;
      fsr_r <= 8'h00;
      mid_r <= 8'h00;
      did_r <= 8'h00;
      busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      cmd_r <= cmd_nxt;
      req_r <= req_nxt;
      kind_r <= kind_nxt;
      wd_r <= wd_nxt;
      fsr_r <= fsr_nxt;
      mid_r <= mid_nxt;
      did_r <= did_nxt;
      busy_r <= busy_nxt;
    end
  end

  // ----------------------------------------------------------------
  // registers, interrupts and pin flops
  // ----------------------------------------------------------------
  always_comb begin
    blk_nxt = blk_r;
    wpen_nxt = wpen_r;
    ien_nxt = ien_r;
    if (cmd_wr) wpen_nxt = reg_wdata_in[NFC_CTRL_WPEN];
    if (reg_wr_in && reg_addr_in == NFC_REG_BLOCK)
      blk_nxt = reg_wdata_in[NFC_BLK_W-1:0];
    if (reg_wr_in && reg_addr_in == NFC_REG_IRQ_EN)
      ien_nxt = reg_wdata_in[2:0];
    // set beats clear in the same cycle
    irq_nxt = irq_r;
    if (reg_wr_in && reg_addr_in == NFC_REG_IRQ_CLR)
      irq_nxt = irq_r & ~reg_wdata_in[2:0];
    irq_nxt = irq_nxt | {ev_rej, ev_fail, ev_done};
    rdat_nxt = 32'h0;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        NFC_REG_CTRL: rdat_nxt = {27'h0, wpen_r, 1'b0, op_r};
        NFC_REG_BLOCK: rdat_nxt = 32'(blk_r);
        NFC_REG_STAT: rdat_nxt = {30'h0, ret_q[0], busy_r};
        NFC_REG_FSTAT: rdat_nxt = {24'h0, fsr_r};
        NFC_REG_ID: rdat_nxt = {16'h0, did_r, mid_r};
        NFC_REG_IRQ: rdat_nxt = {29'h0, irq_r};
        NFC_REG_IRQ_EN: rdat_nxt = {29'h0, ien_r};
        default: rdat_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      blk_r <= '0;
      wpen_r <= 1'b0;
      ien_r <= NFC_IRQ_RST;
      irq_r <= NFC_IRQ_RST;
      rdat_r <= 32'h0;
      // start at the pulled-up idle level, no false busy after reset
      rd_q <= 8'h01;
      ret_q <= 8'h01;
      irq_out <= 1'b0;
      fl_io_out <= 8'h00;
      fl_io_oe_n_out <= 1'b1;
      fl_cle_out <= 1'b0;
      fl_ale_out <= 1'b0;
      fl_ce_n_out <= 1'b1;
      fl_we_n_out <= 1'b1;
      fl_read_strobe_low_out <= 1'b1;
      fl_wp_n_out <= 1'b0;
    end else begin
      blk_r <= blk_nxt;
      wpen_r <= wpen_nxt;
      ien_r <= ien_nxt;
      irq_r <= irq_nxt;
      rdat_r <= rdat_nxt;
      // wired-or ready line, pulled up; low means some die busy
      rd_q <= {7'h0, fl_rdy_in};
      ret_q <= {7'h0, rd_q[0]};
      irq_out <= |(irq_nxt & ien_nxt); // tracks the sticky bits
      fl_io_out <= s_io;
      fl_io_oe_n_out <= s_oe_n;
      fl_cle_out <= s_cle;
      fl_ale_out <= s_ale;
      // chip enable held for the whole sequence, so status keeps
      // flowing while polling
      fl_ce_n_out <= (st_nxt == S_IDLE);
      fl_we_n_out <= s_we_n;
      fl_read_strobe_low_out <= s_rd_stb_n;
      // protection released only when software asks
      fl_wp_n_out <= wpen_r;
    end
  end
  assign reg_rdata_out = rdat_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence erase_head;
    st_r == S_ADDR1 && pins.done;
  endsequence
  chk_conf_after_addr: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    erase_head |=> st_r == S_CONF && wd_r == NFC_CMD_ERASE_GO)
    else $error("confirm not sent after address");
  chk_conf_origin: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    $rose(st_r == S_CONF) |-> $past(st_r) == S_ADDR1)
    else $error("confirm without address cycles");
  chk_busy_reject: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    cmd_wr && busy_r && reg_wdata_in[2:0] == NFC_OP_ID |-> ev_rej)
    else $error("command accepted while busy");
  chk_setup_first: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    st_r == S_ADDR0 && op_r == NFC_OP_ERASE |-> cmd_r ==
    NFC_CMD_ERASE_SETUP)
    else $error("erase address without setup");
  chk_addr_field: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    $rose(st_r == S_ADDR0) && op_r == NFC_OP_ERASE |->
    wd_r[3:0] == 4'h0)
    else $error("ignored address bits not zero");
  // a status or reset write may legally leave the wait early
  chk_wait_ready: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    st_r == S_WAITB && !ret_q[0] && !cmd_wr |=> st_r == S_WAITB)
    else $error("left erase wait while busy");
  chk_status_rsvd: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    (fsr_r & NFC_SR_RSVD_MASK) == 8'h00)
    else $error("reserved status bits set");
  chk_id_addr: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    $rose(st_r == S_ADDR0) && op_r == NFC_OP_ID |-> wd_r ==
    NFC_ID_ADDR)
    else $error("id address not zero");
endmodule
`default_nettype wire

// file: core/nfc_pins_if.sv
// interface bundling the flash-side pin group between the sequencer
// and the strobe engine; assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface nfc_pins_if;
  logic req;
  logic [1:0] kind; // 0 cmd, 1 addr, 2 read
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport seq (output req, output kind, output wdata,
    input done, input rdata);
  modport eng (input req, input kind, input wdata,
    output done, output rdata);
endinterface
`default_nettype wire

// file: core/nfc_pkg.sv
// package for the nand flash host controller: opcodes, register map,
// status fields and strobe timing counts.
// assumes a 100 MHz ref_clk_in and an 8-bit multiplexed flash bus.
package nfc_pkg;
  // ----------------------------------------------------------------
  // flash command bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] NFC_CMD_READ_MAIN = 8'h00;
  localparam logic [7:0] NFC_CMD_READ_SPARE = 8'h50;
  localparam logic [7:0] NFC_CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] NFC_CMD_ERASE_GO = 8'hD0;
  localparam logic [7:0] NFC_CMD_STATUS = 8'h70;
  localparam logic [7:0] NFC_CMD_ID = 8'h90;
  localparam logic [7:0] NFC_CMD_RESET = 8'hFF;
  localparam logic [7:0] NFC_ID_ADDR = 8'h00;
  // ----------------------------------------------------------------
  // flash status byte fields
  // ----------------------------------------------------------------
  localparam int NFC_SR_FAIL = 0;
  localparam int NFC_SR_READY = 6;
  localparam int NFC_SR_UNPROT = 7;
  localparam logic [7:0] NFC_SR_RSVD_MASK = 8'h3E;
  // block select field of the erase address
  localparam int NFC_BLK_LSB = 13;
  localparam int NFC_BLK_MSB = 22;
  localparam int NFC_BLK_W = NFC_BLK_MSB - NFC_BLK_LSB + 1;
  // ----------------------------------------------------------------
  // controller register map (word offsets)
  // ----------------------------------------------------------------
  localparam logic [3:0] NFC_REG_CTRL = 4'h0;
  localparam logic [3:0] NFC_REG_BLOCK = 4'h1;
  localparam logic [3:0] NFC_REG_STAT = 4'h2;
  localparam logic [3:0] NFC_REG_FSTAT = 4'h3;
  localparam logic [3:0] NFC_REG_ID = 4'h4;
  localparam logic [3:0] NFC_REG_IRQ = 4'h5;
  localparam logic [3:0] NFC_REG_IRQ_CLR = 4'h6;
  localparam logic [3:0] NFC_REG_IRQ_EN = 4'h7;
  // ctrl register write codes
  localparam logic [2:0] NFC_OP_ERASE = 3'h1;
  localparam logic [2:0] NFC_OP_STATUS = 3'h2;
  localparam logic [2:0] NFC_OP_ID = 3'h3;
  localparam logic [2:0] NFC_OP_RESET = 3'h4;
  localparam logic [2:0] NFC_OP_READ_MAIN = 3'h5;
  localparam logic [2:0] NFC_OP_READ_SPARE = 3'h6;
  localparam int NFC_CTRL_WPEN = 4;
  // irq bits
  localparam int NFC_IRQ_DONE = 0;
  localparam int NFC_IRQ_FAIL = 1;
  localparam int NFC_IRQ_REJ = 2;
  localparam logic [2:0] NFC_IRQ_RST = 3'h0;
  // ----------------------------------------------------------------
  // strobe timing
  // ----------------------------------------------------------------
  localparam int NFC_CLK_NS = 10;
  localparam int NFC_PULSE_NS = 30;
  localparam int NFC_PULSE_CYC = (NFC_PULSE_NS + NFC_CLK_NS - 1) / NFC_CLK_NS;
  localparam logic [3:0] NFC_PULSE_CNT = 4'(NFC_PULSE_CYC);
endpackage

// file: core/nfc_strobe.sv
// strobe engine: one command, address or read cycle on the flash bus.
// assumes requests only arrive while it is idle.
`timescale 1ns/1ps
`default_nettype none
module nfc_strobe
  import nfc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  nfc_pins_if.eng bus,
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic io_oe_n_out,
  output logic cle_out,
  output logic ale_out,
  output logic we_n_out,
  output logic read_strobe_low_out
);
  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} nfc_stb_t;
  nfc_stb_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] rd_r, rd_nxt;
  logic [1:0] kind_r, kind_nxt;
  logic [7:0] wd_r, wd_nxt;
  logic done_r, done_nxt;

  // ----------------------------------------------------------------
  // pulse sequencing: low phase then recovery high phase
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    rd_nxt = rd_r;
    kind_nxt = kind_r;
    wd_nxt = wd_r;
    done_nxt = 1'b0;
    unique case (st_r)
      ST_IDLE: if (bus.req) begin
        kind_nxt = bus.kind;
        wd_nxt = bus.wdata;
        cnt_nxt = NFC_PULSE_CNT;
        st_nxt = ST_LOW;
      end
      ST_LOW: if (cnt_r == 4'h1) begin
        // sample read data just before the read strobe rises
        if (kind_r == 2'd2) rd_nxt = io_in;
        cnt_nxt = NFC_PULSE_CNT;
        st_nxt = ST_HIGH;
      end else begin
        cnt_nxt = cnt_r - 4'h1;
      end
      ST_HIGH: if (cnt_r == 4'h1) begin
        done_nxt = 1'b1;
        st_nxt = ST_IDLE;
      end else begin
        cnt_nxt = cnt_r - 4'h1;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      rd_r <= 8'h00;
      kind_r <= 2'd0;
      wd_r <= 8'h00;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      rd_r <= rd_nxt;
      kind_r <= kind_nxt;
      wd_r <= wd_nxt;
      done_r <= done_nxt;
    end
  end

  // pins derived from state; top registers them again
  always_comb begin
    cle_out = (st_r != ST_IDLE) && (kind_r == 2'd0);
    ale_out = (st_r != ST_IDLE) && (kind_r == 2'd1);
    we_n_out = !((st_r == ST_LOW) && (kind_r != 2'd2));
    read_strobe_low_out = !((st_r == ST_LOW) && (kind_r == 2'd2));
    io_out = wd_r;
    io_oe_n_out = !((st_r != ST_IDLE) && (kind_r != 2'd2));
  end
  assign bus.done = done_r;
  assign bus.rdata = rd_r;
endmodule
`default_nettype wire

// file: tb/nfc_flash_model.sv
// behavioural flash device: command decode, block erase, status, id.
// assumes the bench merges io and resolves the pulled-up ready line.
`timescale 1ns/1ps
`default_nettype none
module nfc_flash_model #(
  parameter logic [7:0] MAKER = 8'hA5, // arbitrary value
  parameter logic [7:0] DEVICE = 8'h3C // arbitrary value
) (
  input wire logic cle_in,
  input wire logic ale_in,
  input wire logic ce_n_in,
  input wire logic we_n_in,
  input wire logic read_strobe_low_in,
  input wire logic wp_n_in,
  input wire logic [7:0] io_in,
  input wire logic [31:0] op_ns_in,
  input wire logic fail_next_in,
  output logic [7:0] io_out,
  output logic busy_out // pull-down enable of the open-drain line
);
  // ----------------------------------------------------------------
  // command state
  // ----------------------------------------------------------------
  logic [7:0] mode_r = 8'h00; // power-up in main read mode
  logic [1:0] addr_cnt = 2'h0;
  logic [7:0] addr_b1 = 8'h00;
  logic [7:0] addr_b2 = 8'h00;
  logic setup_ok = 1'b0;
  logic fail_r = 1'b0;
  logic id_idx = 1'b0;
  logic [7:0] last_q = 8'h00;
  logic [7:0] rd_byte;
  logic [9:0] erased_blk = 10'h000;
  int erase_cnt = 0;
  logic vcc_ok = 1'b1; // supply detector, held good here
  event op_go;
  initial busy_out = 1'b0;
  // decode on the rising write strobe; busy admits status and reset only
  always @(posedge we_n_in) begin
    if (!ce_n_in && vcc_ok) begin
      if (cle_in && (!busy_out || io_in == 8'h70 || io_in == 8'hFF)) begin
        if (io_in == 8'hD0 && setup_ok && addr_cnt == 2'h2) begin
          if (wp_n_in) begin
            erased_blk = {addr_b2[5:0], addr_b1[7:4]};
            fail_r = fail_next_in;
            erase_cnt++;
            busy_out = 1'b1;
            -> op_go;
          end else begin
            fail_r = 1'b1;
          end
        end
        if (io_in == 8'hFF) begin
          busy_out = 1'b1;
          -> op_go;
        end
        setup_ok = (io_in == 8'h60);
        addr_cnt = 2'h0;
        id_idx = 1'b0;
        mode_r = io_in; // mode holds until next command
      end else if (ale_in && setup_ok && !busy_out) begin
        if (addr_cnt == 2'h0) addr_b1 = io_in;
        else addr_b2 = io_in;
        addr_cnt = addr_cnt + 2'h1;
      end
    end
  end
  // internal operation timer; a retrigger while running is not seen
  always @(op_go) begin
    #(op_ns_in);
    busy_out = 1'b0;
  end
  // read byte follows live state, no strobe toggle needed
  always_comb begin
    rd_byte = ~last_q;
    if (mode_r == 8'h70) rd_byte = {wp_n_in, !busy_out, 5'h00, fail_r};
    if (mode_r == 8'h90) rd_byte = id_idx ? DEVICE : MAKER;
  end
  // drive only while both selects are low, else a changing pattern
  assign io_out = (!ce_n_in && !read_strobe_low_in) ? rd_byte : ~last_q;
  always @(posedge read_strobe_low_in) begin
    last_q = rd_byte;
    if (mode_r == 8'h90) id_idx = 1'b1;
  end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// bench for the flash host controller with a behavioural device.
// assumes the register map and op codes of the controller package.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import nfc_pkg::*;
  typedef struct {logic chk; logic [31:0] exp;} nfc_note_t;
  localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
  localparam logic [7:0] DEVICE = 8'hC3; // arbitrary value
  localparam logic [2:0] OPS [4] = '{NFC_OP_STATUS, NFC_OP_RESET,
    NFC_OP_READ_MAIN, NFC_OP_READ_SPARE};
  localparam logic [7:0] CMDS [4] = '{8'h70, 8'hFF, 8'h00, 8'h50};
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic irq, oe_n, cle, ale, ce_n, we_n, rd_stb_n, wp_n, busy, rdy;
  logic [7:0] io_o, io_dev, io_bus;
  logic [31:0] op_ns = 32'hC8;
  logic fail_next = 1'b0;
  logic [31:0] seed = 32'd53762;
  logic rd_seen = 1'b0;
  logic [9:0] blk;
  int cnt;
  int num_errors = 0;
  int cmp_count = 0;
  nfc_note_t notes[$];
  nfc_note_t nt;
  always #5 ref_clk_in = ~ref_clk_in;
  // shared io: host when enabled, else device; ready is pulled up
  assign io_bus = !oe_n ? io_o : io_dev;
  assign rdy = !busy;
  nfc_ctrl i_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .irq_out(irq),
    .fl_io_in(io_bus), .fl_io_out(io_o), .fl_io_oe_n_out(oe_n),
    .fl_cle_out(cle), .fl_ale_out(ale), .fl_ce_n_out(ce_n),
    .fl_we_n_out(we_n), .fl_read_strobe_low_out(rd_stb_n),
    .fl_wp_n_out(wp_n), .fl_rdy_in(rdy));
  nfc_flash_model #(.MAKER(MAKER), .DEVICE(DEVICE)) i_flash (.cle_in(cle),
    .ale_in(ale), .ce_n_in(ce_n), .we_n_in(we_n),
    .read_strobe_low_in(rd_stb_n), .wp_n_in(wp_n), .io_in(io_bus),
    .op_ns_in(op_ns), .fail_next_in(fail_next), .io_out(io_dev),
    .busy_out(busy));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr <= 1'b0;
    // idle edge: back-to-back calls never drive a strobe twice at once
    @(posedge ref_clk_in);
  endtask
  // the note is taken by the watcher when the data stand
  task automatic reg_read(input logic [3:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    notes.push_back('{1'b1, e});
    @(posedge ref_clk_in);
    reg_rd <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  // look at the level between edges so no update race decides it
  task automatic chk_irq(input logic e);
    @(negedge ref_clk_in);
    cmp(32'(irq), 32'(e));
    @(posedge ref_clk_in);
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 5000) begin
      @(posedge ref_clk_in);
      n++;
    end
    cmp(32'(irq), 32'h1);
  endtask
  task automatic op(input logic [31:0] ctrl, input logic [31:0] irq_exp);
    reg_write(NFC_REG_CTRL, ctrl);
    wait_irq();
    reg_read(NFC_REG_IRQ, irq_exp);
    reg_write(NFC_REG_IRQ_CLR, 32'h7);
    chk_irq(1'b0);
  endtask
  task automatic close_out();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // read watcher and watchdog
  // ----------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (rd_seen && notes.size() > 0) begin
      nt = notes.pop_front();
      if (nt.chk) cmp(reg_rdata, nt.exp);
    end
    rd_seen <= reg_rd;
  end
  initial begin
    #500000;
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    close_out();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    cmp(32'(wp_n), 32'h0);
    cmp(32'(i_flash.mode_r), 32'h0);
    reg_read(NFC_REG_STAT, 32'h2);
    reg_read(NFC_REG_IRQ, 32'h0);
    reg_read(4'hF, 32'h0);
    reg_write(NFC_REG_IRQ_EN, 32'h7);
    op(32'h13, 32'h1);
    reg_read(NFC_REG_ID, {16'h0, DEVICE, MAKER});
    reg_read(NFC_REG_CTRL, 32'h13);
    // pass, slow fail, then write protected
    for (int k = 0; k < 3; k++) begin
      blk = 10'(xs());
      fail_next <= (k == 1);
      op_ns <= (k == 1) ? 32'h4E20 : 32'hC8 + (xs() & 32'h3FF);
      cnt = i_flash.erase_cnt;
      reg_write(NFC_REG_BLOCK, {22'h0, blk});
      reg_read(NFC_REG_BLOCK, {22'h0, blk});
      op(k == 2 ? 32'h1 : 32'h11, k == 0 ? 32'h1 : 32'h3);
      reg_read(NFC_REG_FSTAT, k == 0 ? 32'hC0 : k == 1 ? 32'hC1 : 32'h41);
      cmp(32'(i_flash.erase_cnt), 32'(cnt + (k < 2)));
      if (k < 2) cmp(32'(i_flash.erased_blk), 32'(blk));
    end
    // refusals while busy, with the reject bit masked
    fail_next <= 1'b0;
    op_ns <= 32'h1388;
    reg_write(NFC_REG_IRQ_EN, 32'h1);
    reg_write(NFC_REG_CTRL, 32'h11);
    reg_write(NFC_REG_CTRL, 32'h13);
    reg_write(NFC_REG_CTRL, 32'h17);
    chk_irq(1'b0);
    op(32'h12, 32'h5);
    cmp(32'(i_flash.mode_r), 32'h70);
    reg_write(NFC_REG_IRQ_EN, 32'h7);
    op_ns <= 32'h12C;
    for (int i = 0; i < 4; i++) begin
      op({28'h1, 1'b0, OPS[i]}, 32'h1);
      cmp(32'(i_flash.mode_r), 32'(CMDS[i]));
      if (i == 0) reg_read(NFC_REG_FSTAT, 32'hC0);
    end
    repeat (3) @(posedge ref_clk_in);
    cmp(32'(notes.size()), 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
